// *** logic/fcg_gate.sv ***
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Flash command gate: register port, permission check and launch handshake to the algorithm engine.

// What this block does
// - Unsecured normal mode refuses erase-all, unsecure and field-margin commands.
// - Unsecured special mode refuses only the backdoor key verify command.
// - Secured normal mode behaves as unsecured normal mode.
// - Secured special mode allows only five erase-verify, erase, unsecure, override commands.
// - Erase-verify-all checks every flash and EEPROM block erased.
// - Erase-verify-block checks one addressed flash block erased.
// - Erase-verify-section checks a count of words from an address.
// - Read-once returns the low 16 bits of the addressed word of the one-time 64-byte field.
// - Program-flash programs one phrase at the address.
// - Program-once writes the addressed word of the 64-byte field, each word once only.
// - Erase-all runs only with all three region bits and EEPROM open set.
// - Erase-block runs only with low, high disable and open bits set.
// - Erase-sector erases the addressed flash sector.
// - Unsecure erases and verifies all blocks, then releases security.
// - Backdoor verify compares keys and releases security on a match.
// - User margin level is applied to all flash blocks.
// - Field margin level is applied, only in unsecured special mode.
// - Protection override verifies a key, then overrides protection until reset.
// - EEPROM verify, program and sector erase allowed except secured special.
// - Writing one to command-complete launches; flag stays low until done.
// - An invalid code sets the access error and is not run.
// - Program or erase before a clock divider write sets access error.
module fcg_gate
  import fcg_pkg::*;
#(
  parameter int ONCE_WORDS = 8
) (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        ce_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic        special_mode_in,
  input  wire logic        secured_in,
  input  wire logic        engine_done_in,
  input  wire logic        engine_fail_in,
  input  wire logic        key_match_in,
  input  wire logic        erased_ok_in,
  output logic [31:0]      rdata_out,
  output logic             engine_start_out,
  output logic [7:0]       engine_cmd_out,
  output logic [23:0]      engine_addr_out,
  output logic [15:0]      engine_data_out,
  output logic             release_security_out,
  output logic             protect_override_out,
  output logic [1:0]       margin_level_out,
  output logic             margin_field_out
);

  if (ONCE_WORDS != 8) begin : g_bad_words
    $error("fcg_gate: the one-time field is indexed by three address bits, eight words");
  end

  typedef struct packed {
    fcg_state_t  state;
    logic [7:0]  clkdiv;
    logic        divld;
    logic        command_complete_flag;
    logic        access_error_flag;
    logic        pviol;
    logic [7:0]  code;
    logic [23:0] addr;
    logic [15:0] data;
    logic [7:0]  prot;
    logic [7:0]  eeprot;
    logic [31:0] rdata;
    logic        start;
    logic        release_sec;
    logic        override;
    logic [1:0]  margin;
    logic        margin_field;
    logic        once_wr;
  } fcg_regs_t;

  fcg_regs_t r;
  fcg_regs_t next_r;

  logic        defined;
  logic        allowed;
  logic        prog_erase;
  logic        once_done;
  logic [63:0] once_data;

  fcg_permit u_permit (
    .code_in        (r.code),
    .special_in     (special_mode_in),
    .secured_in     (secured_in),
    .defined_out    (defined),
    .allowed_out    (allowed),
    .prog_erase_out (prog_erase)
  );

  fcg_once_store #(
    .WORDS (ONCE_WORDS)
  ) u_once (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .ce_in     (ce_in),
    .index_in  (r.addr[2:0]),
    .write_in  (r.once_wr),
    .data_in   ({48'h000000000000, r.data}),
    .done_out  (once_done),
    .data_out  (once_data)
  );

  logic protect_all_open;
  logic ee_open;
  assign protect_all_open = r.prot[PROT_LDIS] && r.prot[PROT_HDIS] && r.prot[PROT_OPEN];
  assign ee_open          = r.eeprot[EEPROT_OPEN];

  always_comb begin
    next_r          = r;
    next_r.start    = 1'b0;
    next_r.once_wr  = 1'b0;
    next_r.release_sec = 1'b0;
    next_r.rdata    = 32'h00000000;

    if (rd_in) begin
      unique case (addr_in)
        REG_CLKDIV:  next_r.rdata = {24'h000000, r.clkdiv};
        REG_STATUS:  next_r.rdata = {24'h000000, r.command_complete_flag, 1'b0, r.access_error_flag, r.pviol, r.divld, 3'b000};
        REG_COMMAND: next_r.rdata = {r.code, r.addr};
        REG_PROT:    next_r.rdata = {24'h000000, r.prot};
        REG_EEPROT:  next_r.rdata = {24'h000000, r.eeprot};
        REG_RESULT:  next_r.rdata = {16'h0000, r.data};
        default:     next_r.rdata = 32'h00000000;
      endcase
    end

    if (wr_in) begin
      unique case (addr_in)
        REG_CLKDIV: begin
          next_r.clkdiv = wdata_in[7:0];
          next_r.divld  = 1'b1;
        end
        REG_STATUS: begin
          if (wdata_in[STAT_ACCESS_ERROR_FLAG]) next_r.access_error_flag = 1'b0;
          if (wdata_in[STAT_PVIOL])  next_r.pviol  = 1'b0;
          if (wdata_in[STAT_COMMAND_COMPLETE_FLAG] && r.command_complete_flag && !r.access_error_flag && !r.pviol) begin
            next_r.command_complete_flag  = 1'b0;
            next_r.state = FCG_LAUNCH;
          end
        end
        REG_COMMAND: begin
          if (r.command_complete_flag) begin
            next_r.code = wdata_in[31:24];
            next_r.addr = wdata_in[23:0];
          end
        end
        REG_RESULT: begin
          if (r.command_complete_flag) next_r.data = wdata_in[15:0];
        end
        REG_PROT:   next_r.prot   = wdata_in[7:0];
        REG_EEPROT: next_r.eeprot = wdata_in[7:0];
        default: begin
        end
      endcase
    end

    unique case (r.state)
      FCG_IDLE: begin
      end
      FCG_LAUNCH: begin
        next_r.state = FCG_IDLE;
        next_r.command_complete_flag  = 1'b1;
        if (!defined || !allowed) begin
          next_r.access_error_flag = 1'b1;
        end else if (prog_erase && !r.divld) begin
          next_r.access_error_flag = 1'b1;
        end else if (r.code == CMD_ERASE_ALL && !(protect_all_open && ee_open)) begin
          next_r.pviol = 1'b1;
        end else if (r.code == CMD_ERASE_BLOCK && !protect_all_open) begin
          next_r.pviol = 1'b1;
        end else if (r.code == CMD_READ_ONCE) begin
          next_r.data = once_data[15:0];
        end else if (r.code == CMD_PROGRAM_ONCE) begin
          if (once_done) next_r.access_error_flag = 1'b1;
          else next_r.once_wr = 1'b1;
        end else if (r.code == CMD_USER_MARGIN) begin
          next_r.margin       = r.data[1:0];
          next_r.margin_field = 1'b0;
        end else if (r.code == CMD_FIELD_MARGIN) begin
          next_r.margin       = r.data[1:0];
          next_r.margin_field = 1'b1;
        end else begin
          next_r.command_complete_flag  = 1'b0;
          next_r.start = 1'b1;
          next_r.state = FCG_BUSY;
        end
      end
      FCG_BUSY: begin
        if (engine_done_in) begin
          next_r.state = FCG_IDLE;
          next_r.command_complete_flag  = 1'b1;
          if (engine_fail_in) next_r.access_error_flag = 1'b1;
          if (r.code == CMD_UNSECURE && erased_ok_in) begin
            next_r.release_sec = 1'b1;
          end
          if (r.code == CMD_VERIFY_KEY && key_match_in) begin
            next_r.release_sec = 1'b1;
          end
          if (r.code == CMD_PROT_OVERRIDE && key_match_in) begin
            next_r.override = 1'b1;
          end
        end
      end
      default: begin
        next_r.state = FCG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r              <= '0;
      r.state        <= FCG_IDLE;
      r.clkdiv       <= CLKDIV_RESET;
      r.command_complete_flag         <= 1'b1;
      r.prot         <= PROT_RESET;
      r.eeprot       <= EEPROT_RESET;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  assign rdata_out            = r.rdata;
  assign engine_start_out     = r.start;
  assign engine_cmd_out       = r.code;
  assign engine_addr_out      = r.addr;
  assign engine_data_out      = r.data;
  assign release_security_out = r.release_sec;
  assign protect_override_out = r.override;
  assign margin_level_out     = r.margin;
  assign margin_field_out     = r.margin_field;

endmodule : fcg_gate

// *** logic/fcg_pkg.sv ***
// Package with command codes, register offsets and reset values of the flash command gate.
package fcg_pkg;

  localparam logic [7:0] CMD_ERASE_VERIFY_ALL   = 8'h01;
  localparam logic [7:0] CMD_ERASE_VERIFY_BLOCK = 8'h02;
  localparam logic [7:0] CMD_ERASE_VERIFY_SECT  = 8'h03;
  localparam logic [7:0] CMD_READ_ONCE          = 8'h04;
  localparam logic [7:0] CMD_PROGRAM_FLASH      = 8'h06;
  localparam logic [7:0] CMD_PROGRAM_ONCE       = 8'h07;
  localparam logic [7:0] CMD_ERASE_ALL          = 8'h08;
  localparam logic [7:0] CMD_ERASE_BLOCK        = 8'h09;
  localparam logic [7:0] CMD_ERASE_SECTOR       = 8'h0A;
  localparam logic [7:0] CMD_UNSECURE           = 8'h0B;
  localparam logic [7:0] CMD_VERIFY_KEY         = 8'h0C;
  localparam logic [7:0] CMD_USER_MARGIN        = 8'h0D;
  localparam logic [7:0] CMD_FIELD_MARGIN       = 8'h0E;
  localparam logic [7:0] CMD_EE_VERIFY_SECT     = 8'h10;
  localparam logic [7:0] CMD_EE_PROGRAM         = 8'h11;
  localparam logic [7:0] CMD_EE_ERASE_SECTOR    = 8'h12;
  localparam logic [7:0] CMD_PROT_OVERRIDE      = 8'h13;

  localparam logic [3:0] REG_CLKDIV  = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h1;
  localparam logic [3:0] REG_COMMAND = 4'h2;
  localparam logic [3:0] REG_PROT    = 4'h3;
  localparam logic [3:0] REG_EEPROT  = 4'h4;
  localparam logic [3:0] REG_RESULT  = 4'h5;

  localparam int STAT_COMMAND_COMPLETE_FLAG   = 7;
  localparam int STAT_ACCESS_ERROR_FLAG = 5;
  localparam int STAT_PVIOL  = 4;
  localparam int STAT_DIVLD  = 3;

  localparam int PROT_OPEN = 7;
  localparam int PROT_HDIS = 5;
  localparam int PROT_LDIS = 2;
  localparam int EEPROT_OPEN = 7;

  localparam logic [7:0] CLKDIV_RESET = 8'h00;
  localparam logic [7:0] PROT_RESET   = 8'hFF;
  localparam logic [7:0] EEPROT_RESET = 8'h80;

  typedef enum logic [1:0] {
    FCG_IDLE   = 2'b00,
    FCG_LAUNCH = 2'b01,
    FCG_BUSY   = 2'b10
  } fcg_state_t;

endpackage : fcg_pkg

// *** logic/fcg_permit.sv ***
`timescale 1ns/1ps
// Permission lookup by command code, special mode and security state.
module fcg_permit
  import fcg_pkg::*;
(
  input  wire logic [7:0] code_in,
  input  wire logic       special_in,
  input  wire logic       secured_in,
  output logic            defined_out,
  output logic            allowed_out,
  output logic            prog_erase_out
);

  always_comb begin
    defined_out    = 1'b1;
    allowed_out    = 1'b0;
    prog_erase_out = 1'b0;
    unique case (code_in)
      CMD_ERASE_VERIFY_ALL, CMD_ERASE_VERIFY_BLOCK, CMD_PROT_OVERRIDE: begin
        allowed_out = 1'b1;
      end
      CMD_ERASE_ALL, CMD_UNSECURE: begin
        allowed_out    = special_in;
        prog_erase_out = 1'b1;
      end
      CMD_VERIFY_KEY: begin
        allowed_out = !special_in;
      end
      CMD_FIELD_MARGIN: begin
        allowed_out = special_in && !secured_in;
      end
      CMD_ERASE_VERIFY_SECT, CMD_READ_ONCE, CMD_USER_MARGIN, CMD_EE_VERIFY_SECT: begin
        allowed_out = !(special_in && secured_in);
      end
      CMD_PROGRAM_FLASH, CMD_PROGRAM_ONCE, CMD_ERASE_BLOCK, CMD_ERASE_SECTOR,
      CMD_EE_PROGRAM, CMD_EE_ERASE_SECTOR: begin
        allowed_out    = !(special_in && secured_in);
        prog_erase_out = 1'b1;
      end
      default: begin
        defined_out = 1'b0;
      end
    endcase
  end

endmodule : fcg_permit

// *** logic/fcg_once_store.sv ***
`timescale 1ns/1ps
// One-time field store: each word may be written once and read back.
module fcg_once_store #(
  parameter int WORDS = 8
) (
  input  wire logic                     clk_in,
  input  wire logic                     resetn_in,
  input  wire logic                     ce_in,
  input  wire logic [$clog2(WORDS)-1:0] index_in,
  input  wire logic                     write_in,
  input  wire logic [63:0]              data_in,
  output logic                          done_out,
  output logic [63:0]                   data_out
);

  if (WORDS < 2) begin : g_bad_words
    $error("fcg_once_store needs at least two words");
  end

  logic [63:0]      mem [WORDS];
  logic [WORDS-1:0] used;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      used <= '0;
    end else if (ce_in && write_in && !used[index_in]) begin
      used[index_in] <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (ce_in && write_in && !used[index_in]) begin
      mem[index_in] <= data_in;
    end
  end

  assign done_out = used[index_in];
  assign data_out = used[index_in] ? mem[index_in] : 64'hFFFFFFFFFFFFFFFF;

endmodule : fcg_once_store

// *** test/fcg_gate_props.sv ***
`timescale 1ns/1ps
// Port assertions of the flash command gate.
module fcg_gate_props
  import fcg_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic [3:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic        special_mode_in,
  input wire logic        secured_in,
  input wire logic        engine_done_in,
  input wire logic [31:0] rdata_out,
  input wire logic        engine_start_out,
  input wire logic [7:0]  engine_cmd_out,
  input wire logic        release_security_out,
  input wire logic        protect_override_out
);
  logic [3:0] since;
  logic       busy;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Cycles since the last launch write, and whether the engine holds a command.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      since <= 4'hF;
      busy <= 1'b0;
    end else begin
      if (wr_in && addr_in == REG_STATUS && wdata_in[STAT_COMMAND_COMPLETE_FLAG]) since <= 4'h0;
      else if (since != 4'hF) since <= since + 4'h1;
      if (engine_start_out) busy <= 1'b1;
      else if (engine_done_in) busy <= 1'b0;
    end
  end
  a_start_pulse: assert property (engine_start_out |=> !engine_start_out)
    else $error("start pulse too long");
  a_start_timing: assert property (engine_start_out |-> since == 4'h1)
    else $error("start not two cycles after launch");
  a_secured_special: assert property (engine_start_out && special_mode_in && secured_in
    |-> engine_cmd_out inside {8'h01, 8'h02, 8'h08, 8'h0B, 8'h13})
    else $error("command run in secured special mode");
  a_normal_refuse: assert property (engine_start_out && !special_mode_in
    |-> !(engine_cmd_out inside {8'h08, 8'h0B, 8'h0E}))
    else $error("refused command run in normal mode");
  a_key_special: assert property (engine_start_out && special_mode_in |-> engine_cmd_out != 8'h0C)
    else $error("key verify run in special mode");
  a_defined_only: assert property (engine_start_out |-> engine_cmd_out inside {[8'h01:8'h13]}
    && !(engine_cmd_out inside {8'h05, 8'h0F}))
    else $error("undefined command run");
  a_release_cause: assert property (release_security_out |-> $past(engine_done_in)
    && engine_cmd_out inside {8'h0B, 8'h0C})
    else $error("security released without cause");
  a_override_held: assert property (protect_override_out |=> protect_override_out)
    else $error("override dropped");
  a_flag_busy: assert property (rd_in && addr_in == REG_STATUS && busy && !engine_done_in
    |=> !rdata_out[STAT_COMMAND_COMPLETE_FLAG])
    else $error("complete flag high while busy");
  c_secured_run: cover property (engine_start_out && special_mode_in && secured_in);
  c_release: cover property (release_security_out);
  c_override: cover property ($rose(protect_override_out));
endmodule : fcg_gate_props

// *** test/fcg_engine_model.sv ***
`timescale 1ns/1ps
// Algorithm engine model that finishes launched commands.
module fcg_engine_model (
  input  wire logic clk_in,
  input  wire logic start_in,
  input  wire logic fail_in,
  output logic      done_out,
  output logic      fail_out,
  output logic      key_match_out,
  output logic      erased_ok_out
);
  logic tog = 1'b0;
  initial done_out = 1'b0;
  always @(posedge clk_in) tog <= ~tog;
  // Waits a random time, from none to long, before reporting completion.
  always @(posedge clk_in) begin
    if (start_in) begin
      repeat ($urandom_range(0, 40)) @(posedge clk_in);
      done_out <= 1'b1;
      @(posedge clk_in);
      done_out <= 1'b0;
    end
  end
  // Qualifiers only mean something beside done, so they wander otherwise.
  // A failing engine also reports a key mismatch and a failed erase check.
  assign fail_out = done_out ? fail_in : tog;
  assign key_match_out = done_out ? !fail_in : tog;
  assign erased_ok_out = done_out ? !fail_in : ~tog;
endmodule : fcg_engine_model

// *** test/tb_flash_command_gate.sv ***
`timescale 1ns/1ps
// Self-checking bench of the flash command gate.
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_flash_command_gate
  import fcg_pkg::*;
;
  logic        clk_in = 0, resetn_in = 0, wr_in = 0, rd_in = 0, sp = 0, sec = 0, efail = 0, ce = 1;
  logic [3:0]  addr_in = 0;
  logic [31:0] wdata_in = 0, rdata_out, s;
  logic        done, fail, keym, erok, start, rel, ovr, mfield;
  logic [1:0]  mlevel;
  logic [15:0] edata;
  logic [7:0]  ecmd;
  logic [23:0] eaddr;
  int          n_fail = 0, compares = 0, n_start = 0, n_rel = 0;
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (start) n_start <= n_start + 1;
    if (rel) n_rel <= n_rel + 1;
  end
  fcg_gate u_fcg_gate (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .special_mode_in(sp), .secured_in(sec),
    .engine_done_in(done), .engine_fail_in(fail), .key_match_in(keym), .erased_ok_in(erok),
    .rdata_out(rdata_out), .engine_start_out(start), .engine_cmd_out(ecmd), .engine_addr_out(eaddr),
    .engine_data_out(edata), .release_security_out(rel), .protect_override_out(ovr),
    .margin_level_out(mlevel), .margin_field_out(mfield));
  fcg_engine_model u_fcg_engine_model (.clk_in(clk_in), .start_in(start), .fail_in(efail),
    .done_out(done), .fail_out(fail), .key_match_out(keym), .erased_ok_out(erok));
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd
  function automatic logic perm(input logic [7:0] c, input logic p, input logic q);
    case (c)
      8'h01, 8'h02, 8'h13: return 1'b1;
      8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h0D, 8'h10, 8'h11, 8'h12: return !(p && q);
      8'h08, 8'h0B: return p;
      8'h0C: return !p;
      8'h0E: return p && !q;
      default: return 1'b0;
    endcase
  endfunction : perm
  task automatic run(input logic [7:0] c, input logic [23:0] a, input logic err, input logic viol,
                     input logic go);
    int k, s0, r0;
    s0 = n_start;
    r0 = n_rel;
    k = 0;
    wr(REG_COMMAND, {c, a});
    wr(REG_STATUS, 32'h80);
    do begin rd(REG_STATUS, s); k++; end while (s[STAT_COMMAND_COMPLETE_FLAG] !== 1'b1 && k < 100);
    `CHK(s[STAT_COMMAND_COMPLETE_FLAG], 1'b1)
    `CHK(s[STAT_ACCESS_ERROR_FLAG], err)
    `CHK(s[STAT_PVIOL], viol)
    `CHK(n_start - s0, int'(go))
    if (go) `CHK({ecmd, eaddr}, {c, a})
    `CHK(n_rel - r0, int'(go && !err && c inside {8'h0B, 8'h0C}))
    wr(REG_STATUS, 32'h30);
  endtask : run
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end
  initial begin
    logic [7:0]  c;
    logic [31:0] d;
    logic        ok;
    void'($urandom(62));
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(REG_STATUS, d);
    `CHK(d, 32'h80)
    run(CMD_PROGRAM_FLASH, 24'h0, 1'b1, 1'b0, 1'b0);
    run(CMD_ERASE_VERIFY_ALL, 24'h0, 1'b0, 1'b0, 1'b1);
    s = 32'($urandom_range(1, 255));
    wr(REG_CLKDIV, s);
    ce <= 1'b0;
    wr(REG_CLKDIV, 32'h0000_0000);
    ce <= 1'b1;
    wr(4'hF, 32'hFFFF_FFFF);
    rd(REG_CLKDIV, d);
    `CHK(d, s)
    rd(REG_STATUS, d);
    `CHK(d, 32'h88)
    sp <= 1'b1;
    wr(REG_PROT, 32'hFB);
    run(CMD_ERASE_ALL, 24'h0, 1'b0, 1'b1, 1'b0);
    run(CMD_ERASE_BLOCK, 24'h0, 1'b0, 1'b1, 1'b0);
    wr(REG_PROT, 32'hFF);
    wr(REG_EEPROT, 32'h0);
    run(CMD_ERASE_ALL, 24'h0, 1'b0, 1'b1, 1'b0);
    run(CMD_ERASE_BLOCK, 24'h0, 1'b0, 1'b0, 1'b1);
    wr(REG_EEPROT, 32'h80);
    efail <= 1'b1;
    run(CMD_ERASE_VERIFY_BLOCK, 24'h0, 1'b1, 1'b0, 1'b1);
    run(CMD_UNSECURE, 24'h0, 1'b1, 1'b0, 1'b1);
    run(CMD_PROT_OVERRIDE, 24'h0, 1'b1, 1'b0, 1'b1);
    `CHK(ovr, 1'b0)
    efail <= 1'b0;
    wr(REG_RESULT, 32'h0000_0002);
    run(CMD_USER_MARGIN, 24'h0, 1'b0, 1'b0, 1'b0);
    `CHK(edata, 16'h0002)
    `CHK({mfield, mlevel}, 3'b010)
    wr(REG_RESULT, 32'h0000_1231);
    run(CMD_FIELD_MARGIN, 24'h0, 1'b0, 1'b0, 1'b0);
    `CHK({mfield, mlevel}, 3'b101)
    run(CMD_PROGRAM_ONCE, 24'h7, 1'b0, 1'b0, 1'b0);
    wr(REG_RESULT, 32'h0000_0000);
    run(CMD_READ_ONCE, 24'h7, 1'b0, 1'b0, 1'b0);
    rd(REG_RESULT, d);
    `CHK(d, 32'h0000_1231)
    run(CMD_PROGRAM_ONCE, 24'h7, 1'b1, 1'b0, 1'b0);
    for (int m = 0; m < 4; m++) begin
      sp <= m[1];
      sec <= m[0];
      for (int i = 1; i < 21; i++) begin
        c = 8'(i);
        ok = perm(c, m[1], m[0]);
        run(c, {21'($urandom), 3'(m)}, !ok, 1'b0, ok && !(c inside {8'h04, 8'h07, 8'h0D, 8'h0E}));
      end
    end
    repeat (8) run(8'($urandom_range(21, 255)), 24'h0, 1'b1, 1'b0, 1'b0);
    `CHK(ovr, 1'b1)
    print_verdict();
  end
endmodule : tb_flash_command_gate
bind fcg_gate fcg_gate_props u_fcg_gate_props (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .special_mode_in(special_mode_in),
  .secured_in(secured_in), .engine_done_in(engine_done_in), .rdata_out(rdata_out),
  .engine_start_out(engine_start_out), .engine_cmd_out(engine_cmd_out),
  .release_security_out(release_security_out), .protect_override_out(protect_override_out));
